// *** dspcg_pkg.sv ***
// Package for the deep-sleep port clock gating block.
// Assumes a single 25 MHz system clock and an APB master with 32-bit data.
package dspcg_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_SW_RESET_CTRL_ZERO = 12'h040; // Reset control, capability masked
  localparam logic [11:0] OFS_RUN_CLOCK_CONFIG = 12'h060; // Holds the auto gating select bit
  localparam logic [11:0] OFS_RUN_PORT_GATE = 12'h108; // Run-mode port gating
  localparam logic [11:0] OFS_SLEEP_PORT_GATE = 12'h118; // Sleep-mode port gating
  localparam logic [11:0] OFS_DEEP_SLEEP_PORT_GATE = 12'h128; // Deep-sleep port gating
  localparam logic [11:0] OFS_FAULT_STATUS = 12'h150; // Sticky fault flags, write one to clear
  localparam logic [11:0] OFS_FAULT_MASK = 12'h154; // Interrupt mask, same layout
  localparam logic [11:0] OFS_GATE_STATUS = 12'h158; // Live applied enables, read only

  // Field positions and widths
  localparam int NUM_PORTS = 8; // Ports A to H
  localparam int AUTO_GATING_BIT = 27; // Auto gating select in run clock configuration

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000; // Every register resets to zero
  localparam logic [7:0] RST_PORTS = 8'h00; // All ports unclocked after reset

  // Power modes seen by the gating selector
  typedef enum logic [1:0] {
    DSPCG_MODE_RUN,
    DSPCG_MODE_SLEEP,
    DSPCG_MODE_DEEP
  } dspcg_mode_t;

  // APB request bundle from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dspcg_apb_req_t;

  // APB answer bundle to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dspcg_apb_rsp_t;

  // Port access request seen by the fault checker
  typedef struct packed {
    logic valid;
    logic [2:0] port;
  } dspcg_port_acc_t;
endpackage

// *** dspcg_top.sv ***
// Port clock gating controller with APB registers, fault checks and reset control.
// Assumes the APB master and the port access requests are synchronous to mclk;
// the enables feed latch-based clock gate cells next to each port.
//
// Behaviour
// [RL1] Set enable bit clocks port, clear stops it
// [RL2] Access to unclocked port answers bus fault
// [RL3] Deep-sleep gating enables reset to zero
// [RL4] Bits 0..7 read-write, ports A..H ascending
// [RL5] Upper bits read zero, ignore writes
// [RL6] Mode picks run, sleep or deep gating
// [RL7] Sleep gating registers need auto gating set
// [RL8] Reset control writes masked by capability bits
// [RL9] Auto gating clear applies run gating always
// [RL10] Gated clock switches without glitches
module dspcg_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // APB slave
  input wire dspcg_pkg::dspcg_apb_req_t apb_req,
  output dspcg_pkg::dspcg_apb_rsp_t apb_rsp,
  // Power mode requests
  input wire logic sleep_mode,
  input wire logic deep_sleep_mode,
  // Capability mask for reset control writes
  input wire logic [31:0] capability_mask_one,
  // Accesses aimed at the ports
  input wire dspcg_pkg::dspcg_port_acc_t port_acc,
  output logic port_acc_fault,
  // Port clock enables and hold signals
  output logic [7:0] port_clock_enable,
  output logic [7:0] port_hold_disabled,
  // Software reset lines
  output logic [31:0] sw_reset_out,
  // Interrupt
  output logic irq
);

  // Register storage
  logic [31:0] sw_reset_ctrl_zero; // Reset control word
  logic [31:0] run_clock_configuration; // Only auto gating select is kept
  logic [7:0] run_port_clock_gate; // Run-mode enables
  logic [7:0] sleep_port_clock_gate; // Sleep-mode enables
  logic [7:0] deep_sleep_port_clock_gate; // Deep-sleep enables
  logic [7:0] fault_status; // Sticky fault flags per port
  logic [7:0] fault_mask; // Interrupt mask per port
  logic auto_gating_select;
  dspcg_pkg::dspcg_mode_t mode;
  logic [7:0] next_enable; // Enables chosen for this mode
  logic [7:0] fault_set; // Fault events this cycle
  logic [7:0] fault_clr; // Software clears this cycle
  logic wr_en; // Write completes this edge
  logic rd_en; // Read answer being prepared
  logic addr_ok;

  // Decode a byte offset into a known-register flag
  function automatic logic is_mapped(input logic [11:0] a);
    case (a)
      dspcg_pkg::OFS_SW_RESET_CTRL_ZERO,
      dspcg_pkg::OFS_RUN_CLOCK_CONFIG,
      dspcg_pkg::OFS_RUN_PORT_GATE,
      dspcg_pkg::OFS_SLEEP_PORT_GATE,
      dspcg_pkg::OFS_DEEP_SLEEP_PORT_GATE,
      dspcg_pkg::OFS_FAULT_STATUS,
      dspcg_pkg::OFS_FAULT_MASK,
      dspcg_pkg::OFS_GATE_STATUS: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // Decode a write strobe for one offset
  function automatic logic wr_hit(input logic we, input logic [11:0] a, input logic [11:0] o);
    wr_hit = we && (a == o);
  endfunction

  assign auto_gating_select = run_clock_configuration[dspcg_pkg::AUTO_GATING_BIT];
  assign addr_ok = is_mapped(apb_req.paddr);
  // Writes land only at the completing edge of the access phase
  assign wr_en = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
  assign rd_en = apb_req.psel && apb_req.penable && !apb_rsp.pready && !apb_req.pwrite;

  // Current power mode; deep sleep outranks sleep
  always_comb begin
    if (deep_sleep_mode) begin
      mode = dspcg_pkg::DSPCG_MODE_DEEP;
    end else if (sleep_mode) begin
      mode = dspcg_pkg::DSPCG_MODE_SLEEP;
    end else begin
      mode = dspcg_pkg::DSPCG_MODE_RUN;
    end
  end

  // Pick the gating register for the mode
  always_comb begin
    if (!auto_gating_select) begin
      next_enable = run_port_clock_gate; // RL9
    end else begin
      case (mode) // RL6
        dspcg_pkg::DSPCG_MODE_SLEEP: next_enable = sleep_port_clock_gate; // RL7
        dspcg_pkg::DSPCG_MODE_DEEP: next_enable = deep_sleep_port_clock_gate; // RL7
        default: next_enable = run_port_clock_gate;
      endcase
    end
  end

  // APB handshake: one wait state, so every answer comes from flops
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      apb_rsp.pready <= 1'b0;
      apb_rsp.pslverr <= 1'b0;
    end else begin
      apb_rsp.pready <= apb_req.psel && apb_req.penable && !apb_rsp.pready;
      apb_rsp.pslverr <= apb_req.psel && apb_req.penable && !apb_rsp.pready && !addr_ok;
    end
  end

  // Read data mux, registered during the wait state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      apb_rsp.prdata <= dspcg_pkg::RST_WORD;
    end else if (rd_en) begin
      case (apb_req.paddr)
        dspcg_pkg::OFS_SW_RESET_CTRL_ZERO: apb_rsp.prdata <= sw_reset_ctrl_zero;
        dspcg_pkg::OFS_RUN_CLOCK_CONFIG: apb_rsp.prdata <= run_clock_configuration;
        dspcg_pkg::OFS_RUN_PORT_GATE: apb_rsp.prdata <= {24'h000000, run_port_clock_gate};
        dspcg_pkg::OFS_SLEEP_PORT_GATE: apb_rsp.prdata <= {24'h000000, sleep_port_clock_gate};
        // Upper bits read zero
        dspcg_pkg::OFS_DEEP_SLEEP_PORT_GATE: begin
          apb_rsp.prdata <= {24'h000000, deep_sleep_port_clock_gate}; // RL5
        end
        dspcg_pkg::OFS_FAULT_STATUS: apb_rsp.prdata <= {24'h000000, fault_status};
        dspcg_pkg::OFS_FAULT_MASK: apb_rsp.prdata <= {24'h000000, fault_mask};
        dspcg_pkg::OFS_GATE_STATUS: apb_rsp.prdata <= {24'h000000, port_clock_enable};
        default: apb_rsp.prdata <= dspcg_pkg::RST_WORD;
      endcase
    end else begin
      apb_rsp.prdata <= dspcg_pkg::RST_WORD;
    end
  end

  // Gating registers; only the low eight bits exist
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      run_port_clock_gate <= dspcg_pkg::RST_PORTS;
      sleep_port_clock_gate <= dspcg_pkg::RST_PORTS;
      deep_sleep_port_clock_gate <= dspcg_pkg::RST_PORTS; // RL3
    end else begin
      if (wr_hit(wr_en, apb_req.paddr, dspcg_pkg::OFS_RUN_PORT_GATE)) begin
        run_port_clock_gate <= apb_req.pwdata[7:0];
      end
      if (wr_hit(wr_en, apb_req.paddr, dspcg_pkg::OFS_SLEEP_PORT_GATE)) begin
        sleep_port_clock_gate <= apb_req.pwdata[7:0];
      end
      // Bit 0 is port A up to bit 7 port H; bits 31:8 dropped
      if (wr_hit(wr_en, apb_req.paddr, dspcg_pkg::OFS_DEEP_SLEEP_PORT_GATE)) begin
        deep_sleep_port_clock_gate <= apb_req.pwdata[7:0]; // RL4 RL5
      end
    end
  end

  // Clock configuration word; only the auto gating bit is writable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      run_clock_configuration <= dspcg_pkg::RST_WORD;
    end else if (wr_hit(wr_en, apb_req.paddr, dspcg_pkg::OFS_RUN_CLOCK_CONFIG)) begin
      run_clock_configuration <= apb_req.pwdata & (32'h0000_0001 << dspcg_pkg::AUTO_GATING_BIT);
    end
  end

  // Reset control: bits without capability keep their value
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sw_reset_ctrl_zero <= dspcg_pkg::RST_WORD;
    end else if (wr_hit(wr_en, apb_req.paddr, dspcg_pkg::OFS_SW_RESET_CTRL_ZERO)) begin
      sw_reset_ctrl_zero <= (apb_req.pwdata & capability_mask_one)
                          | (sw_reset_ctrl_zero & ~capability_mask_one); // RL8
    end
  end

  // Applied enables, one flop per port so the gate cell sees a clean level
  generate
    for (genvar p = 0; p < dspcg_pkg::NUM_PORTS; p++) begin : g_port
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          port_clock_enable[p] <= 1'b0;
          port_hold_disabled[p] <= 1'b1;
        end else begin
          // Registered level changes only on mclk, never mid-pulse
          port_clock_enable[p] <= next_enable[p]; // RL1 RL10
          port_hold_disabled[p] <= !next_enable[p]; // RL1
        end
      end
    end
  endgenerate

  // Fault events: access to a port whose clock is stopped
  always_comb begin
    fault_set = 8'h00;
    if (port_acc.valid && !port_clock_enable[port_acc.port]) begin
      fault_set[port_acc.port] = 1'b1; // RL2
    end
  end

  // Bus fault answer, one cycle after the access
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      port_acc_fault <= 1'b0;
    end else begin
      port_acc_fault <= |fault_set; // RL2
    end
  end

  assign fault_clr = wr_hit(wr_en, apb_req.paddr, dspcg_pkg::OFS_FAULT_STATUS)
                   ? apb_req.pwdata[7:0] : 8'h00;

  // Sticky status; a new fault beats a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fault_status <= dspcg_pkg::RST_PORTS;
    end else begin
      fault_status <= (fault_status & ~fault_clr) | fault_set;
    end
  end

  // Interrupt mask
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fault_mask <= dspcg_pkg::RST_PORTS;
    end else if (wr_hit(wr_en, apb_req.paddr, dspcg_pkg::OFS_FAULT_MASK)) begin
      fault_mask <= apb_req.pwdata[7:0];
    end
  end

  // Level interrupt, one cycle behind status
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(fault_status & fault_mask);
    end
  end

  // Software reset lines follow the control word
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sw_reset_out <= dspcg_pkg::RST_WORD;
    end else begin
      sw_reset_out <= sw_reset_ctrl_zero;
    end
  end

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_deep_auto;
    auto_gating_select && mode == dspcg_pkg::DSPCG_MODE_DEEP;
  endsequence

  sequence s_no_auto;
    !auto_gating_select;
  endsequence

  chk_enable_follow: assert property (port_clock_enable == $past(next_enable)) // RL1
    else $error("Port enables do not follow the selected gating");
  chk_hold_inverse: assert property (port_hold_disabled == ~port_clock_enable) // RL1
    else $error("Hold and enable disagree");
  chk_fault_on_gated: assert property (
    port_acc.valid && !port_clock_enable[port_acc.port] |=> port_acc_fault) // RL2
    else $error("Access to gated port gave no fault");
  chk_no_fault_clocked: assert property (
    !(port_acc.valid && !port_clock_enable[port_acc.port]) |=> !port_acc_fault) // RL2
    else $error("Fault without gated access");
  chk_deep_reset_zero: assert property (
    $past(sys_rst) |-> deep_sleep_port_clock_gate == 8'h00) // RL3
    else $error("Deep-sleep gating not zero after reset");
  chk_deep_write_map: assert property (
    wr_hit(wr_en, apb_req.paddr, dspcg_pkg::OFS_DEEP_SLEEP_PORT_GATE)
    |=> deep_sleep_port_clock_gate == $past(apb_req.pwdata[7:0])) // RL4
    else $error("Deep-sleep gating write lost");
  chk_upper_zero: assert property (
    $past(rd_en) && $past(apb_req.paddr) == dspcg_pkg::OFS_DEEP_SLEEP_PORT_GATE
    |-> apb_rsp.prdata[31:8] == 24'h000000) // RL5
    else $error("Upper gating bits read nonzero");
  // One cycle after deep sleep with auto gating, the deep register is applied
  chk_deep_select: assert property (
    s_deep_auto |=> port_clock_enable == $past(deep_sleep_port_clock_gate)) // RL6
    else $error("Deep-sleep gating not applied");
  chk_auto_needed: assert property (
    s_no_auto ##1 s_no_auto |-> port_clock_enable == $past(run_port_clock_gate)) // RL7
    else $error("Sleep gating used without auto gating");
  chk_run_default: assert property (s_no_auto |-> next_enable == run_port_clock_gate) // RL9
    else $error("Run gating not applied with auto gating clear");
  chk_reset_mask: assert property (
    wr_en |=> ((sw_reset_ctrl_zero ^ $past(sw_reset_ctrl_zero))
    & ~$past(capability_mask_one)) == 32'h0000_0000) // RL8
    else $error("Reset control bit changed without capability");
  chk_enable_stable: assert property (
    $changed(port_clock_enable) |-> port_clock_enable == $past(next_enable)) // RL10
    else $error("Enable changed outside a registered step");
endmodule

// *** deep_sleep_port_clock_gating_bench.sv ***
// Self-checking bench for the deep-sleep port clock gating block.
// Assumes one 25 MHz clock, an APB master driven here and no other partner.
module deep_sleep_port_clock_gating_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // Design stimulus, all given a value at time zero
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic sleep_mode = 1'b0;
  logic deep_sleep_mode = 1'b0;
  logic [31:0] capability_mask_one = 32'h0000_0000;
  dspcg_pkg::dspcg_apb_req_t req = '0;
  dspcg_pkg::dspcg_port_acc_t pacc = '0;
  // Design outputs
  dspcg_pkg::dspcg_apb_rsp_t rsp;
  logic port_acc_fault;
  logic irq;
  logic [7:0] port_clock_enable;
  logic [7:0] port_hold_disabled;
  logic [31:0] sw_reset_out;
  // Bookkeeping
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  integer seed = 32'hFF06;
  // Reference model state
  logic [31:0] m_run, m_slp, m_deep, m_srst, m_stat, m_mask, cap, d;
  logic m_auto;
  logic [7:0] m_en;

  // Free-running 40 ns clock
  always #20 mclk = ~mclk;

  dspcg_top dspcg_top_inst (
    .mclk(mclk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
    .sleep_mode(sleep_mode), .deep_sleep_mode(deep_sleep_mode),
    .capability_mask_one(capability_mask_one), .port_acc(pacc),
    .port_acc_fault(port_acc_fault), .port_clock_enable(port_clock_enable),
    .port_hold_disabled(port_hold_disabled), .sw_reset_out(sw_reset_out), .irq(irq)
  );

  // Single comparison point, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One APB transfer; waits for pready with a bound, never a fixed count
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic err);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge mclk);
    req.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    rdat = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // Read and compare data and error flag
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] x;
    logic er;
    apb(1'b0, a, 32'h0000_0000, x, er);
    chk(x, e);
    chk(er, ee);
  endtask

  // Write; error flag expected only on unmapped places
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic ee);
    logic [31:0] x;
    logic er;
    apb(1'b1, a, v, x, er);
    chk(er, ee);
  endtask

  // Applied enables against the mode-selected model register
  task automatic gate_chk();
    logic [7:0] ne;
    // Mode inputs are read only after their edge has passed
    repeat (3) @(posedge mclk);
    m_en = (m_auto && deep_sleep_mode) ? m_deep[7:0] :
           (m_auto && sleep_mode) ? m_slp[7:0] : m_run[7:0];
    ne = ~m_en;
    @(negedge mclk);
    chk(port_clock_enable, m_en);
    chk(port_hold_disabled, ne);
  endtask

  // One access attempt to a port; fault only when it is unclocked
  task automatic hit(input logic [2:0] p);
    @(posedge mclk);
    pacc <= '{valid: 1'b1, port: p};
    @(posedge mclk);
    pacc.valid <= 1'b0;
    @(negedge mclk);
    chk(port_acc_fault, !m_en[p]);
    if (!m_en[p]) m_stat[p] = 1'b1;
  endtask

  // Hang guard, far above the expected length of the run
  always @(posedge mclk) begin
    cycles++;
    if (cycles >= 8000) begin
      bad_count++;
      stop_test();
    end
  end

  // Main sequence
  initial begin
    {m_run, m_slp, m_deep, m_srst, m_stat, m_mask, m_auto} = '0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(dspcg_pkg::OFS_DEEP_SLEEP_PORT_GATE, 32'h0000_0000, 1'b0);
    rd(dspcg_pkg::OFS_SW_RESET_CTRL_ZERO, 32'h0000_0000, 1'b0);
    gate_chk();
    wr(12'h0FC, 32'hFFFF_FFFF, 1'b1);
    rd(12'h0FC, 32'h0000_0000, 1'b1);
    for (int it = 0; it < 6; it++) begin
      // Random gating words; upper bits must be dropped
      m_run = $random(seed);
      m_slp = $random(seed);
      m_deep = $random(seed);
      m_mask = $random(seed);
      m_auto = it[0];
      d = $random(seed);
      d[27] = m_auto;
      wr(dspcg_pkg::OFS_RUN_PORT_GATE, m_run, 1'b0);
      wr(dspcg_pkg::OFS_SLEEP_PORT_GATE, m_slp, 1'b0);
      wr(dspcg_pkg::OFS_DEEP_SLEEP_PORT_GATE, m_deep, 1'b0);
      wr(dspcg_pkg::OFS_RUN_CLOCK_CONFIG, d, 1'b0);
      wr(dspcg_pkg::OFS_FAULT_MASK, m_mask, 1'b0);
      {m_run, m_slp, m_deep, m_mask} = {m_run & 32'hFF, m_slp & 32'hFF,
                                        m_deep & 32'hFF, m_mask & 32'hFF};
      rd(dspcg_pkg::OFS_DEEP_SLEEP_PORT_GATE, m_deep, 1'b0);
      rd(dspcg_pkg::OFS_RUN_PORT_GATE, m_run, 1'b0);
      rd(dspcg_pkg::OFS_SLEEP_PORT_GATE, m_slp, 1'b0);
      rd(dspcg_pkg::OFS_RUN_CLOCK_CONFIG, {4'h0, m_auto, 27'h0}, 1'b0);
      rd(dspcg_pkg::OFS_FAULT_MASK, m_mask, 1'b0);
      // Run, sleep and deep sleep, deep sleep with sleep also raised
      for (int md = 0; md < 3; md++) begin
        // Mode inputs change on a rising edge, never after a negedge check
        @(posedge mclk);
        sleep_mode <= (md == 1) || (md == 2 && it[1]);
        deep_sleep_mode <= (md == 2);
        gate_chk();
        rd(dspcg_pkg::OFS_GATE_STATUS, {24'h0, m_en}, 1'b0);
        for (int p = 0; p < 8; p++) hit(p[2:0]);
      end
      // Interrupt from sticky faults, then clear by writing ones
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk(irq, |(m_stat & m_mask));
      rd(dspcg_pkg::OFS_FAULT_STATUS, m_stat, 1'b0);
      wr(dspcg_pkg::OFS_FAULT_STATUS, m_stat, 1'b0);
      m_stat = 32'h0000_0000;
      rd(dspcg_pkg::OFS_FAULT_STATUS, 32'h0000_0000, 1'b0);
      chk(irq, 1'b0);
      // Reset control write masked by capability bits
      cap = $random(seed);
      d = $random(seed);
      capability_mask_one <= cap;
      wr(dspcg_pkg::OFS_SW_RESET_CTRL_ZERO, d, 1'b0);
      m_srst = (m_srst & ~cap) | (d & cap);
      rd(dspcg_pkg::OFS_SW_RESET_CTRL_ZERO, m_srst, 1'b0);
      @(negedge mclk);
      chk(sw_reset_out, m_srst);
    end
    stop_test();
  end
endmodule
